// [core/slt_cfg.svh]
`ifndef SLT_CFG_SVH
`define SLT_CFG_SVH

`define SLT_SECT_W 8
`define SLT_NSECT 256
`define SLT_IDX_W 10
`define SLT_LOCK_ON 8'h00
`define SLT_LOCK_OFF 8'hFF
`define SLT_PTP_RESET 8'h00
`define SLT_ERASED 8'hFF
`define SLT_OTP_RAND_BYTES 10'h010
`define SLT_STAT1_DELIV 8'h00
`define SLT_CR1_DELIV 8'h00
`define SLT_ABT_DELIV 8'h00
`define SLT_PWD_DELIV 8'hFF
`define SLT_PLOCK_DELIV 8'hFF
`define SLT_ASP_DELIV 16'hFE7F
`define SLT_TRAIN_BITS 4'h8

`endif

// [core/slt_pkg.sv]
package slt_pkg;

    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_DLK_READ,
        CMD_DLK_WRITE,
        CMD_PLK_READ,
        CMD_PLK_PROG,
        CMD_PLK_ERASE,
        CMD_PTP_READ,
        CMD_PTP_PROG,
        CMD_LTP_READ,
        CMD_LTP_WRITE,
        CMD_DELIV_READ
    } slt_cmd_e;

    typedef enum logic [2:0] {
        DV_ARRAY,
        DV_OTP,
        DV_STATUS1,
        DV_CONFIG1,
        DV_AUTOBOOT,
        DV_PASSWORD,
        DV_PLOCK,
        DV_ASP
    } slt_deliv_e;

    typedef enum logic {
        TR_IDLE,
        TR_SHIFT
    } slt_train_e;

endpackage

// [core/slt_regs.sv]
// Functional notes
// - Dynamic lock byte 00h protects the sector
// - Dynamic lock FFh leaves sector open; resets FFh
// - One-time training pattern, default 00h, cleared by reset before the live copy, so never sent
// - Live pattern copy enables and drives training output
// - Host may rewrite live pattern any time
// - Delivered array bytes read FFh
// - Delivered OTP: 16 random bytes, rest FFh
// - Delivered status, config, autoboot registers are 00h
// - Delivered sector-protect config reads FE7Fh
// - Persistent lock 00h protects, FFh leaves open
`timescale 1ns/1ps
`include "slt_cfg.svh"

module slt_regs #(
    parameter logic [127:0] OTP_RANDOM = 128'h0123456789ABCDEF0F1E2D3C4B5A6978 // Arbitrary value
) (
    input wire logic SYS_CLK, // System clock
    input wire logic RESET_N, // Async reset
    input wire logic CMD_VALID, // Command strobe
    input wire slt_pkg::slt_cmd_e CMD_CODE, // Command
    input wire logic [`SLT_IDX_W-1:0] CMD_ADDR, // Sector or byte index
    input wire slt_pkg::slt_deliv_e DELIV_SEL, // Delivered-state item
    input wire logic [7:0] CMD_WDATA, // Write byte
    output logic [15:0] RDATA, // Read data
    output logic RDATA_VALID, // Read data pulse
    input wire logic PE_REQ, // Program/erase check request
    input wire logic [`SLT_SECT_W-1:0] PE_SECTOR, // Sector to check
    output logic PE_GRANT, // Program/erase allowed pulse
    output logic PE_DENY, // Program/erase refused pulse
    input wire logic TRAIN_START, // First dummy cycle of DDR read
    input wire logic DUMMY_ACTIVE, // Dummy cycles in progress
    output logic TRAIN_OUT, // Training pattern bit
    output logic TRAIN_OE // Training bit driven
);

    logic dyn_lock_r [`SLT_NSECT];
    logic pers_lock_r [`SLT_NSECT];
    logic [7:0] ptp_r;
    logic ptp_done_r;
    logic [7:0] live_r;
    logic load_pend_r;
    logic [15:0] rdata_r;
    logic rvalid_r;
    logic grant_r;
    logic deny_r;
    slt_pkg::slt_train_e tr_state_r;
    slt_pkg::slt_train_e tr_state_nxt;
    logic [7:0] tr_shift_r;
    logic [3:0] tr_cnt_r;

    function automatic logic [15:0] lock_byte(input logic open_bit);
        lock_byte = {8'h00, open_bit ? `SLT_LOCK_OFF : `SLT_LOCK_ON};
    endfunction

    function automatic logic [15:0] deliv_value(input slt_pkg::slt_deliv_e sel,
                                                input logic [`SLT_IDX_W-1:0] idx);
        logic [7:0] rnd;
        rnd = OTP_RANDOM[{idx[3:0], 3'h0} +: 8];
        case (sel)
            slt_pkg::DV_ARRAY: deliv_value = {8'h00, `SLT_ERASED};
            slt_pkg::DV_OTP: deliv_value = {8'h00,
                (idx < `SLT_OTP_RAND_BYTES) ? rnd : `SLT_ERASED};
            slt_pkg::DV_STATUS1: deliv_value = {8'h00, `SLT_STAT1_DELIV};
            slt_pkg::DV_CONFIG1: deliv_value = {8'h00, `SLT_CR1_DELIV};
            slt_pkg::DV_AUTOBOOT: deliv_value = {8'h00, `SLT_ABT_DELIV};
            slt_pkg::DV_PASSWORD: deliv_value = {8'h00, `SLT_PWD_DELIV};
            slt_pkg::DV_PLOCK: deliv_value = {8'h00, `SLT_PLOCK_DELIV};
            slt_pkg::DV_ASP: deliv_value = `SLT_ASP_DELIV;
            default: deliv_value = 16'h0000;
        endcase
    endfunction

    wire [`SLT_SECT_W-1:0] sect = CMD_ADDR[`SLT_SECT_W-1:0];
    wire is_cmd = CMD_VALID;
    wire dlk_wr = is_cmd && (CMD_CODE == slt_pkg::CMD_DLK_WRITE);
    wire plk_prog = is_cmd && (CMD_CODE == slt_pkg::CMD_PLK_PROG);
    wire plk_erase = is_cmd && (CMD_CODE == slt_pkg::CMD_PLK_ERASE);
    wire ptp_prog = is_cmd && (CMD_CODE == slt_pkg::CMD_PTP_PROG) && !ptp_done_r;
    wire ltp_wr = is_cmd && (CMD_CODE == slt_pkg::CMD_LTP_WRITE);
    wire is_read = is_cmd && (CMD_CODE == slt_pkg::CMD_DLK_READ
        || CMD_CODE == slt_pkg::CMD_PLK_READ || CMD_CODE == slt_pkg::CMD_PTP_READ
        || CMD_CODE == slt_pkg::CMD_LTP_READ || CMD_CODE == slt_pkg::CMD_DELIV_READ);
    wire deliv_rd = is_cmd && (CMD_CODE == slt_pkg::CMD_DELIV_READ);
    wire [15:0] read_val =
        (CMD_CODE == slt_pkg::CMD_DLK_READ) ? lock_byte(dyn_lock_r[sect]) :
        (CMD_CODE == slt_pkg::CMD_PLK_READ) ? lock_byte(pers_lock_r[sect]) :
        (CMD_CODE == slt_pkg::CMD_PTP_READ) ? {8'h00, ptp_r} :
        (CMD_CODE == slt_pkg::CMD_LTP_READ) ? {8'h00, live_r} :
        deliv_value(DELIV_SEL, CMD_ADDR);
    wire pe_locked = !dyn_lock_r[PE_SECTOR] || !pers_lock_r[PE_SECTOR];
    // Live pattern of zero leaves the outputs undriven
    wire train_en = (live_r != 8'h00);

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < `SLT_NSECT; i++) begin
                dyn_lock_r[i] <= 1'b1;
            end
        end else if (dlk_wr) begin
            dyn_lock_r[sect] <= (CMD_WDATA != `SLT_LOCK_ON);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < `SLT_NSECT; i++) begin
                pers_lock_r[i] <= 1'b1;
            end
        end else if (plk_erase) begin
            for (int i = 0; i < `SLT_NSECT; i++) begin
                pers_lock_r[i] <= 1'b1;
            end
        end else if (plk_prog) begin
            pers_lock_r[sect] <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ptp_r <= `SLT_PTP_RESET;
            ptp_done_r <= 1'b0;
        end else if (ptp_prog) begin
            ptp_r <= CMD_WDATA;
            ptp_done_r <= 1'b1;
        end
    end

    // Copy after reset; host rewrite wins
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            live_r <= `SLT_PTP_RESET;
            load_pend_r <= 1'b1;
        end else begin
            load_pend_r <= 1'b0;
            if (ltp_wr) begin
                live_r <= CMD_WDATA;
            end else if (load_pend_r) begin
                live_r <= ptp_r;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
            grant_r <= 1'b0;
            deny_r <= 1'b0;
        end else begin
            rvalid_r <= is_read;
            if (is_read) begin
                rdata_r <= read_val;
            end
            grant_r <= PE_REQ && !pe_locked;
            deny_r <= PE_REQ && pe_locked;
        end
    end

    always_comb begin
        tr_state_nxt = tr_state_r;
        case (tr_state_r)
            slt_pkg::TR_IDLE: begin
                if (TRAIN_START && train_en) begin
                    tr_state_nxt = slt_pkg::TR_SHIFT;
                end
            end
            slt_pkg::TR_SHIFT: begin
                if (!DUMMY_ACTIVE || tr_cnt_r == `SLT_TRAIN_BITS - 4'h1) begin
                    tr_state_nxt = slt_pkg::TR_IDLE;
                end
            end
            default: tr_state_nxt = slt_pkg::TR_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tr_state_r <= slt_pkg::TR_IDLE;
            tr_shift_r <= 8'h00;
            tr_cnt_r <= 4'h0;
        end else begin
            tr_state_r <= tr_state_nxt;
            if (tr_state_r == slt_pkg::TR_IDLE) begin
                tr_shift_r <= live_r;
                tr_cnt_r <= 4'h0;
            end else begin
                tr_shift_r <= {tr_shift_r[6:0], 1'b0};
                tr_cnt_r <= tr_cnt_r + 4'h1;
            end
        end
    end

    assign RDATA = rdata_r;
    assign RDATA_VALID = rvalid_r;
    assign PE_GRANT = grant_r;
    assign PE_DENY = deny_r;
    assign TRAIN_OUT = (tr_state_r == slt_pkg::TR_SHIFT) && tr_shift_r[7];
    assign TRAIN_OE = (tr_state_r == slt_pkg::TR_SHIFT);

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_dlk_lock;
        dlk_wr && CMD_WDATA == `SLT_LOCK_ON;
    endsequence
    sequence s_dlk_rd_same;
        is_cmd && CMD_CODE == slt_pkg::CMD_DLK_READ && sect == $past(sect, 2);
    endsequence
    // Write, one idle cycle, then read of the same sector
    sequence s_dlk_gap_read;
        s_dlk_lock ##1 !CMD_VALID ##1 s_dlk_rd_same;
    endsequence
    sequence s_train_go;
        TRAIN_START && train_en && tr_state_r == slt_pkg::TR_IDLE ##1 DUMMY_ACTIVE;
    endsequence
    sequence s_train_lead;
        TRAIN_OE && TRAIN_OUT == $past(live_r[7]) ##1 TRAIN_OE;
    endsequence
    sequence s_asp_rd;
        deliv_rd && DELIV_SEL == slt_pkg::DV_ASP;
    endsequence
    sequence s_otp_tail_rd;
        deliv_rd && DELIV_SEL == slt_pkg::DV_OTP && CMD_ADDR >= `SLT_OTP_RAND_BYTES;
    endsequence
    sequence s_stat_rd;
        deliv_rd && DELIV_SEL == slt_pkg::DV_STATUS1;
    endsequence

    a_dlk_lock_read: assert property (s_dlk_gap_read |=> RDATA == 16'h0000)
        else $error("dynamic lock did not read back 00h");
    a_locked_refused: assert property (PE_REQ && pe_locked |=> PE_DENY && !PE_GRANT)
        else $error("locked sector not refused");
    a_open_granted: assert property (PE_REQ && !pe_locked |=> PE_GRANT && !PE_DENY)
        else $error("open sector not granted");
    a_plk_protects: assert property (PE_REQ && !pers_lock_r[PE_SECTOR] |=> PE_DENY)
        else $error("persistent lock did not protect");
    a_ptp_frozen: assert property (ptp_done_r |=> $stable(ptp_r))
        else $error("training pattern changed after programming");
    a_live_write: assert property (ltp_wr |=> live_r == $past(CMD_WDATA))
        else $error("live pattern not updated");
    a_train_bits: assert property (s_train_go |-> s_train_lead)
        else $error("training pattern not driven");
    a_asp_deliv: assert property (s_asp_rd |=> RDATA == 16'hFE7F && RDATA_VALID)
        else $error("protect config default wrong");
    a_otp_tail: assert property (s_otp_tail_rd |=> RDATA == 16'h00FF)
        else $error("OTP tail not erased");
    a_status_deliv: assert property (s_stat_rd |=> RDATA == 16'h0000)
        else $error("status default not 00h");

endmodule

// [verif/slt_host_model.sv]
`timescale 1ns/1ps
module slt_host_model (
    input wire logic SYS_CLK, // System clock
    input wire logic BURST, // Start one DDR read latency phase
    input wire logic TRAIN_OUT, // Training bit from device
    input wire logic TRAIN_OE, // Training bit driven
    output logic TRAIN_START, // First dummy cycle
    output logic DUMMY_ACTIVE, // Dummy cycles running
    output logic [7:0] CAP, // Captured pattern
    output logic [3:0] NBITS // Captured bit count
);
    logic [3:0] cnt_r = 4'h0;
    logic start_r = 1'b0;
    logic dummy_r = 1'b0;
    logic [7:0] cap_r = 8'h00;
    logic [3:0] nbits_r = 4'h0;
    assign TRAIN_START = start_r;
    assign DUMMY_ACTIVE = dummy_r;
    assign CAP = cap_r;
    assign NBITS = nbits_r;
    always @(posedge SYS_CLK) begin
        start_r <= 1'b0;
        if (BURST) begin
            start_r <= 1'b1;
            dummy_r <= 1'b1;
            cnt_r <= 4'hA;
            cap_r <= 8'h00;
            nbits_r <= 4'h0;
        end else begin
            if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1) dummy_r <= 1'b0;
            if (TRAIN_OE) begin
                cap_r <= {cap_r[6:0], TRAIN_OUT};
                nbits_r <= nbits_r + 4'h1;
            end
        end
    end
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
`include "slt_cfg.svh"
module testbench;
    localparam logic [127:0] OTP = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
    logic clk = 1'b0, rst_n = 1'b0, cv = 1'b0, pe_req = 1'b0, burst = 1'b0;
    slt_pkg::slt_cmd_e code = slt_pkg::CMD_NONE;
    slt_pkg::slt_deliv_e dsel = slt_pkg::DV_ARRAY;
    logic [9:0] addr = 10'h000;
    logic [7:0] wd = 8'h00, pe_sec = 8'h00, cap;
    logic [15:0] rdata;
    logic rv, grant, deny, tout, toe, tstart, dact;
    logic [3:0] nbits;
    int num_errors = 0, n_tests = 0, cyc = 0;
    slt_regs #(.OTP_RANDOM(OTP)) i_dut (.SYS_CLK(clk), .RESET_N(rst_n), .CMD_VALID(cv),
        .CMD_CODE(code), .CMD_ADDR(addr), .DELIV_SEL(dsel), .CMD_WDATA(wd), .RDATA(rdata),
        .RDATA_VALID(rv), .PE_REQ(pe_req), .PE_SECTOR(pe_sec), .PE_GRANT(grant),
        .PE_DENY(deny), .TRAIN_START(tstart), .DUMMY_ACTIVE(dact), .TRAIN_OUT(tout),
        .TRAIN_OE(toe));
    slt_host_model i_host (.SYS_CLK(clk), .BURST(burst), .TRAIN_OUT(tout), .TRAIN_OE(toe),
        .TRAIN_START(tstart), .DUMMY_ACTIVE(dact), .CAP(cap), .NBITS(nbits));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task print_verdict();
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
    task chk(string name, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task cmd(slt_pkg::slt_cmd_e c, logic [9:0] a, logic [7:0] d, slt_pkg::slt_deliv_e s);
        @(posedge clk);
        cv <= 1'b1;
        code <= c;
        addr <= a;
        wd <= d;
        dsel <= s;
        @(posedge clk);
        cv <= 1'b0;
    endtask
    task rd(slt_pkg::slt_cmd_e c, logic [9:0] a, slt_pkg::slt_deliv_e s, logic [15:0] e);
        cmd(c, a, 8'h00, s);
        #1;
        chk("rdata_valid", {15'h0000, rv}, 16'h0001);
        chk("rdata", rdata, e);
    endtask
    task wr(slt_pkg::slt_cmd_e c, logic [9:0] a, logic [7:0] d);
        cmd(c, a, d, slt_pkg::DV_ARRAY);
    endtask
    task pe(logic [7:0] s, logic [1:0] e);
        @(posedge clk);
        pe_req <= 1'b1;
        pe_sec <= s;
        @(posedge clk);
        pe_req <= 1'b0;
        #1;
        chk("grant_deny", {14'h0000, grant, deny}, {14'h0000, e});
    endtask
    task train(logic [7:0] e, logic [3:0] n);
        @(posedge clk);
        burst <= 1'b1;
        @(posedge clk);
        burst <= 1'b0;
        repeat (14) @(posedge clk);
        #1;
        chk("train_bits", {12'h000, nbits}, {12'h000, n});
        chk("train_pattern", {8'h00, cap}, {8'h00, e});
    endtask
    logic [15:0] dexp [8];
    initial begin
        dexp = '{16'h00FF, {8'h00, OTP[7:0]}, 16'h0000, 16'h0000, 16'h0000, 16'h00FF,
            16'h00FF, 16'hFE7F};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(slt_pkg::CMD_DLK_READ, 10'h005, slt_pkg::DV_ARRAY, 16'h00FF);
        rd(slt_pkg::CMD_PLK_READ, 10'h0FF, slt_pkg::DV_ARRAY, 16'h00FF);
        rd(slt_pkg::CMD_PTP_READ, 10'h000, slt_pkg::DV_ARRAY, 16'h0000);
        pe(8'h05, 2'b10);
        wr(slt_pkg::CMD_DLK_WRITE, 10'h005, 8'h00);
        rd(slt_pkg::CMD_DLK_READ, 10'h005, slt_pkg::DV_ARRAY, 16'h0000);
        pe(8'h05, 2'b01);
        pe(8'h06, 2'b10);
        wr(slt_pkg::CMD_DLK_WRITE, 10'h005, 8'hFF);
        pe(8'h05, 2'b10);
        wr(slt_pkg::CMD_PLK_PROG, 10'h0FF, 8'h00);
        rd(slt_pkg::CMD_PLK_READ, 10'h0FF, slt_pkg::DV_ARRAY, 16'h0000);
        pe(8'hFF, 2'b01);
        wr(slt_pkg::CMD_PLK_ERASE, 10'h000, 8'h00);
        pe(8'hFF, 2'b10);
        for (int i = 0; i < 8; i++) begin
            rd(slt_pkg::CMD_DELIV_READ, 10'h000, slt_pkg::slt_deliv_e'(i), dexp[i]);
        end
        rd(slt_pkg::CMD_DELIV_READ, 10'h00F, slt_pkg::DV_OTP, {8'h00, OTP[127:120]});
        rd(slt_pkg::CMD_DELIV_READ, 10'h010, slt_pkg::DV_OTP, 16'h00FF);
        train(8'h00, 4'h0);
        wr(slt_pkg::CMD_LTP_WRITE, 10'h000, 8'hA5);
        rd(slt_pkg::CMD_LTP_READ, 10'h000, slt_pkg::DV_ARRAY, 16'h00A5);
        train(8'hA5, 4'h8);
        wr(slt_pkg::CMD_PTP_PROG, 10'h000, 8'h3C);
        wr(slt_pkg::CMD_PTP_PROG, 10'h000, 8'h11);
        rd(slt_pkg::CMD_PTP_READ, 10'h000, slt_pkg::DV_ARRAY, 16'h003C);
        rd(slt_pkg::CMD_LTP_READ, 10'h000, slt_pkg::DV_ARRAY, 16'h00A5);
        wr(slt_pkg::CMD_DLK_WRITE, 10'h005, 8'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        // Reset returns the one-time pattern to its unprogrammed default
        train(8'h00, 4'h0);
        rd(slt_pkg::CMD_PTP_READ, 10'h000, slt_pkg::DV_ARRAY, 16'h0000);
        rd(slt_pkg::CMD_LTP_READ, 10'h000, slt_pkg::DV_ARRAY, 16'h0000);
        rd(slt_pkg::CMD_DELIV_READ, 10'h000, slt_pkg::DV_ASP, 16'hFE7F);
        rd(slt_pkg::CMD_DLK_READ, 10'h005, slt_pkg::DV_ARRAY, 16'h00FF);
        print_verdict();
    end
endmodule
